// *** inc/mhri_defines.svh ***
// register offsets, field positions, reset values and timing counts of the modem host register interface
`ifndef MHRI_DEFINES_SVH
`define MHRI_DEFINES_SVH
`define MHRI_REG_DATA_LO 3'h0
`define MHRI_REG_DATA_HI 3'h1
`define MHRI_REG_ADDR_LO 3'h2
`define MHRI_REG_PDATA 3'h3
`define MHRI_REG_CTRL 3'h4
`define MHRI_REG_STATUS 3'h5
`define MHRI_REG_FRAME 3'h7
`define MHRI_CTRL_ADDR8 0
`define MHRI_CTRL_REQ 1
`define MHRI_CTRL_DIR 2
`define MHRI_CTRL_SEND 3
`define MHRI_CTRL_PMODE 4
`define MHRI_CTRL_RAM_IRQ_ENABLE 5
`define MHRI_CTRL_RX_IRQ_ENABLE 6
`define MHRI_CTRL_TX_IRQ_ENABLE 7
`define MHRI_CTRL_RESET 8'h00
`define MHRI_STAT_RESET 8'h40
`define MHRI_FRAME_RESET 8'h00
`define MHRI_FW_VERSION 8'h11
`define MHRI_FLAG_BYTE 8'h7E
`define MHRI_ABORT_BYTE 8'hFF
`define MHRI_MARK 1'b1
`define MHRI_RAM_WAIT 4'h3
`define MHRI_BIT_TIMES_EOF 8
`define MHRI_BIT_CYCLES 16'h208B
`define MHRI_FIFO_DEPTH 8
`endif

// *** inc/mhri_pkg.sv ***
// types of the modem host register interface
package mhri_pkg;
    typedef enum logic [1:0] {
        MHRI_RAM_IDLE,
        MHRI_RAM_WAIT,
        MHRI_RAM_DONE
    } mhri_ram_state_t;
endpackage : mhri_pkg

// *** rtl/mhri_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module mhri_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data_i;
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : mhri_fifo
`default_nettype wire

// *** rtl/mhri_top.sv ***
// host register port of the modem data pump
`timescale 1ns/10ps
`default_nettype none
`include "mhri_defines.svh"
module mhri_top (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] register_select_i,
    input wire logic host_cs_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_o,
    output logic host_irq_n_o,
    input wire logic request_to_send_n_i,
    output logic transmit_mode_o,
    output logic parallel_mode_o,
    output logic line_signal_detect_n_o,
    input wire logic serial_rx_data_i,
    output logic serial_rx_data_o,
    input wire logic standby_i,
    input wire logic data_mode_ready_i,
    input wire logic qam2400_mode_i,
    input wire logic retrain_seen_i,
    input wire logic retrain_active_i,
    input wire logic dialing_i,
    input wire logic tx_drained_i,
    output logic [8:0] ram_addr_o,
    output logic ram_we_o,
    output logic [15:0] ram_wdata_o,
    input wire logic [15:0] ram_rdata_i,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    output logic tx_byte_valid_o,
    input wire logic tx_byte_ready_i,
    output logic [7:0] tx_byte_o,
    input wire logic rx_frame_good_i,
    input wire logic rx_frame_crc_err_i,
    input wire logic rx_frame_abort_i,
    input wire logic rx_frame_first_i,
    input wire logic tx_frame_close_i,
    input wire logic tx_closing_flag_i
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [2:0] sel_s1;
        logic [2:0] sel_s2;
        logic cs_s1;
        logic cs_s2;
        logic rd_s1;
        logic rd_s2;
        logic wr_s1;
        logic wr_s2;
        logic [7:0] din_s1;
        logic [7:0] din_s2;
        logic rts_s1;
        logic rts_s2;
        logic rxd_s1;
        logic rxd_s2;
        logic rd_prev;
        logic wr_prev;
        logic [7:0] data_lo;
        logic [7:0] data_hi;
        logic [7:0] addr_lo;
        logic [7:0] pdata;
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [7:0] frame;
        logic [7:0] rdata;
        logic oe;
        mhri_pkg::mhri_ram_state_t ram_st;
        logic [3:0] ram_cnt;
        logic ram_we;
        logic [15:0] bit_div;
        logic [3:0] eof_bits;
        logic standby_prev;
    } mhri_state_t;
    mhri_state_t s_q;
    mhri_state_t s_d;
    logic fifo_in_ready;
    logic fifo_push;
    logic rd_strobe;
    logic wr_strobe;
    logic rx_take;
    logic frame_event;
    logic bit_tick;
    logic ram_irq;
    logic rx_irq;
    logic tx_irq;
    assign rd_strobe = !s_q.cs_s2 && !s_q.rd_s2 && s_q.rd_prev;
    assign wr_strobe = !s_q.cs_s2 && !s_q.wr_s2 && s_q.wr_prev;
    assign frame_event = rx_frame_good_i || rx_frame_crc_err_i || rx_frame_abort_i;
    // one pulse per received bit time; the end-of-frame hold counts these, not raw clocks
    assign bit_tick = (s_q.bit_div == 16'h0000);
    // the pump only takes a received byte while the host side is parallel
    assign rx_take = rx_byte_valid_i && s_q.ctrl[`MHRI_CTRL_PMODE] && !s_q.stat[6];
    assign fifo_push = wr_strobe && (s_q.sel_s2 == `MHRI_REG_PDATA) && s_q.ctrl[`MHRI_CTRL_PMODE];
    // ************************************************************
    // transmit buffer
    // ************************************************************
    // host writes to the data register in parallel mode queue here; a full queue drops the byte
    mhri_fifo #(
        .WIDTH(8),
        .DEPTH(`MHRI_FIFO_DEPTH)
    ) u_tx_fifo (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(s_q.din_s2),
        .out_valid_o(tx_byte_valid_o),
        .out_ready_i(tx_byte_ready_i),
        .out_data_o(tx_byte_o)
    );
    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        // each pin passes two flops; only the second stage feeds any decode
        s_d.sel_s1 = register_select_i;
        s_d.sel_s2 = s_q.sel_s1;
        s_d.cs_s1 = host_cs_n_i;
        s_d.cs_s2 = s_q.cs_s1;
        s_d.rd_s1 = host_rd_n_i;
        s_d.rd_s2 = s_q.rd_s1;
        s_d.wr_s1 = host_wr_n_i;
        s_d.wr_s2 = s_q.wr_s1;
        s_d.din_s1 = host_data_i;
        s_d.din_s2 = s_q.din_s1;
        s_d.rts_s1 = request_to_send_n_i;
        s_d.rts_s2 = s_q.rts_s1;
        s_d.rxd_s1 = serial_rx_data_i;
        s_d.rxd_s2 = s_q.rxd_s1;
        s_d.rd_prev = s_q.cs_s2 || s_q.rd_s2;
        s_d.wr_prev = s_q.cs_s2 || s_q.wr_s2;
        s_d.ram_we = 1'b0;
        s_d.standby_prev = standby_i;
        s_d.oe = !s_q.cs_s2 && !s_q.rd_s2;
        s_d.stat[0] = 1'b0;
        s_d.stat[3] = 1'b0;
        // ****************************************
        // register reads
        // ****************************************
        if (rd_strobe) begin
            case (s_q.sel_s2)
                `MHRI_REG_DATA_LO: s_d.rdata = s_q.data_lo;
                `MHRI_REG_DATA_HI: s_d.rdata = s_q.data_hi;
                `MHRI_REG_PDATA: s_d.rdata = s_q.pdata;
                `MHRI_REG_CTRL: s_d.rdata = s_q.ctrl;
                `MHRI_REG_STATUS: s_d.rdata = s_q.stat;
                `MHRI_REG_FRAME: s_d.rdata = s_q.frame;
                default: s_d.rdata = 8'h00;
            endcase
            if (s_q.sel_s2 == `MHRI_REG_STATUS) begin
                s_d.stat[5] = 1'b0;
            end
            if (s_q.sel_s2 == `MHRI_REG_PDATA) begin
                s_d.stat[6] = 1'b0;
            end
        end
        // ****************************************
        // register writes
        // ****************************************
        if (wr_strobe) begin
            case (s_q.sel_s2)
                `MHRI_REG_DATA_LO: s_d.data_lo = s_q.din_s2;
                `MHRI_REG_DATA_HI: s_d.data_hi = s_q.din_s2;
                `MHRI_REG_ADDR_LO: s_d.addr_lo = s_q.din_s2;
                `MHRI_REG_PDATA: s_d.stat[7] = 1'b0;
                `MHRI_REG_CTRL: begin
                    s_d.ctrl = s_q.din_s2;
                    if (s_q.din_s2[`MHRI_CTRL_REQ]) begin
                        s_d.stat[5] = 1'b0;
                    end
                end
                // the host is expected to leave the frame status alone
                `MHRI_REG_FRAME: s_d.frame = {5'h00, s_q.din_s2[2:0]};
                default: s_d.ctrl = s_d.ctrl;
            endcase
        end
        // ****************************************
        // ram access sequencer
        // ****************************************
        // a fixed wait models the pump's service time
        case (s_q.ram_st)
            mhri_pkg::MHRI_RAM_IDLE: begin
                if (s_q.ctrl[`MHRI_CTRL_REQ]) begin
                    s_d.ram_st = mhri_pkg::MHRI_RAM_WAIT;
                    s_d.ram_cnt = `MHRI_RAM_WAIT;
                end
            end
            mhri_pkg::MHRI_RAM_WAIT: begin
                if (s_q.ram_cnt == 4'h0) begin
                    s_d.ram_st = mhri_pkg::MHRI_RAM_DONE;
                    s_d.ram_we = s_q.ctrl[`MHRI_CTRL_DIR];
                end else begin
                    s_d.ram_cnt = s_q.ram_cnt - 4'h1;
                end
            end
            mhri_pkg::MHRI_RAM_DONE: begin
                if (!s_q.ctrl[`MHRI_CTRL_DIR]) begin
                    s_d.data_lo = ram_rdata_i[7:0];
                    s_d.data_hi = ram_rdata_i[15:8];
                end
                s_d.ctrl[`MHRI_CTRL_REQ] = 1'b0;
                s_d.stat[5] = 1'b1;
                s_d.ram_st = mhri_pkg::MHRI_RAM_IDLE;
            end
            default: s_d.ram_st = mhri_pkg::MHRI_RAM_IDLE;
        endcase
        // a host write that clears the request aborts the access
        if (s_q.ram_st == mhri_pkg::MHRI_RAM_WAIT && !s_q.ctrl[`MHRI_CTRL_REQ]) begin
            s_d.ram_st = mhri_pkg::MHRI_RAM_IDLE;
            s_d.ram_we = 1'b0;
        end
        // ****************************************
        // modem status
        // ****************************************
        s_d.stat[1] = data_mode_ready_i && !retrain_active_i && !standby_i;
        // retrain flag holds until the pump leaves qam mode
        if (qam2400_mode_i && retrain_seen_i) begin
            s_d.stat[2] = 1'b1;
        end else if (!qam2400_mode_i) begin
            s_d.stat[2] = 1'b0;
        end
        if ((transmit_mode_o && s_q.ctrl[`MHRI_CTRL_SEND]) || dialing_i) begin
            s_d.stat[4] = 1'b1;
        end else if (!s_q.ctrl[`MHRI_CTRL_SEND] && tx_drained_i) begin
            s_d.stat[4] = 1'b0;
        end
        // ****************************************
        // parallel data flow
        // ****************************************
        // hardware sets win over host clears
        if (fifo_push || (tx_byte_valid_o && tx_byte_ready_i)) begin
            s_d.pdata = fifo_push ? s_q.din_s2 : s_d.pdata;
        end
        if (tx_byte_valid_o && tx_byte_ready_i && s_q.ctrl[`MHRI_CTRL_PMODE]) begin
            s_d.stat[7] = 1'b1;
        end
        if (rx_take) begin
            s_d.pdata = rx_byte_i;
            s_d.stat[6] = 1'b1;
        end
        // ****************************************
        // bit-time divider
        // ****************************************
        // restarted by each frame end so the end-of-frame hold spans whole bit times
        if (frame_event || bit_tick) begin
            s_d.bit_div = `MHRI_BIT_CYCLES - 16'h0001;
        end else begin
            s_d.bit_div = s_q.bit_div - 16'h0001;
        end
        if (bit_tick && s_q.eof_bits != 4'h0) begin
            s_d.eof_bits = s_q.eof_bits - 4'h1;
        end
        // ****************************************
        // hdlc receive status
        // ****************************************
        if (rx_frame_first_i && s_q.eof_bits == 4'h0) begin
            s_d.frame[0] = 1'b0;
            s_d.frame[1] = 1'b0;
        end
        if (frame_event) begin
            s_d.frame[0] = 1'b1;
            s_d.stat[6] = 1'b1;
            s_d.eof_bits = 4'(`MHRI_BIT_TIMES_EOF);
            if (rx_frame_good_i) begin
                s_d.frame[1] = 1'b0;
                s_d.pdata = `MHRI_FLAG_BYTE;
            end else begin
                s_d.frame[1] = 1'b1;
                s_d.pdata = rx_frame_abort_i ? `MHRI_ABORT_BYTE : `MHRI_FLAG_BYTE;
            end
        end
        // ****************************************
        // hdlc transmit status
        // ****************************************
        if (tx_frame_close_i) begin
            s_d.frame[2] = 1'b1;
        end else if (tx_closing_flag_i) begin
            s_d.frame[2] = 1'b0;
        end
        // ****************************************
        // standby entry
        // ****************************************
        // acts on the rising edge only, so a held standby does not keep reloading
        if (standby_i && !s_q.standby_prev) begin
            s_d.pdata = `MHRI_FW_VERSION;
            s_d.stat[4] = 1'b0;
            s_d.frame = `MHRI_FRAME_RESET;
        end
    end
    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            // strobe stages reset to the idle high level so no false edge follows reset
            s_q.sel_s1 <= 3'h0;
            s_q.cs_s1 <= 1'b1;
            s_q.cs_s2 <= 1'b1;
            s_q.rd_s1 <= 1'b1;
            s_q.rd_s2 <= 1'b1;
            s_q.wr_s1 <= 1'b1;
            s_q.wr_s2 <= 1'b1;
            s_q.rts_s1 <= 1'b1;
            s_q.rts_s2 <= 1'b1;
            s_q.rxd_s1 <= 1'b1;
            s_q.rxd_s2 <= 1'b1;
            s_q.rd_prev <= 1'b1;
            s_q.wr_prev <= 1'b1;
            s_q.ctrl <= `MHRI_CTRL_RESET;
            s_q.stat <= `MHRI_STAT_RESET | 8'h01;
            s_q.frame <= `MHRI_FRAME_RESET;
            s_q.pdata <= `MHRI_FW_VERSION;
            s_q.ram_st <= mhri_pkg::MHRI_RAM_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
    // ************************************************************
    // outputs
    // ************************************************************
    assign host_data_o = s_q.rdata;
    assign host_data_oe_o = s_q.oe;
    assign ram_irq = s_q.stat[5] && s_q.ctrl[`MHRI_CTRL_RAM_IRQ_ENABLE];
    // receive and transmit sources only count in parallel mode
    assign rx_irq = s_q.stat[6] && s_q.ctrl[`MHRI_CTRL_RX_IRQ_ENABLE] && s_q.ctrl[`MHRI_CTRL_PMODE];
    assign tx_irq = s_q.stat[7] && s_q.ctrl[`MHRI_CTRL_TX_IRQ_ENABLE] && s_q.ctrl[`MHRI_CTRL_PMODE];
    assign host_irq_n_o = !(ram_irq || rx_irq || tx_irq);
    assign transmit_mode_o = s_q.ctrl[`MHRI_CTRL_SEND] || !s_q.rts_s2;
    assign parallel_mode_o = s_q.ctrl[`MHRI_CTRL_PMODE];
    assign line_signal_detect_n_o = !s_q.stat[1];
    assign serial_rx_data_o = s_q.stat[1] ? s_q.rxd_s2 : `MHRI_MARK;
    assign ram_addr_o = {s_q.ctrl[`MHRI_CTRL_ADDR8], s_q.addr_lo};
    assign ram_we_o = s_q.ram_we;
    assign ram_wdata_o = {s_q.data_hi, s_q.data_lo};
endmodule : mhri_top
`default_nettype wire

// *** verif/mhri_asserts.sv ***
// concurrent checks on the ports of the host register port
`timescale 1ns/10ps
`default_nettype none
module mhri_asserts (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic host_cs_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_data_oe_o,
    input wire logic host_irq_n_o,
    input wire logic request_to_send_n_i,
    input wire logic transmit_mode_o,
    input wire logic line_signal_detect_n_o,
    input wire logic serial_rx_data_o,
    input wire logic standby_i,
    input wire logic data_mode_ready_i,
    input wire logic ram_we_o,
    input wire logic tx_byte_valid_o,
    input wire logic tx_byte_ready_i,
    input wire logic [7:0] tx_byte_o
);
    // ****************
    // port properties
    // ****************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // pin path runs through a two-flop synchroniser, hence the held spans
    sequence s_rts_held; !request_to_send_n_i [*4]; endsequence
    sequence s_no_carrier; !data_mode_ready_i [*3]; endsequence
    sequence s_rd_idle; host_rd_n_i [*5]; endsequence
    a_rts_sets_tx: assert property (s_rts_held |-> transmit_mode_o)
        else $error("transmit mode missing with send pin held low");
    a_lsd_follows_ready: assert property (s_no_carrier |-> line_signal_detect_n_o)
        else $error("line signal detect asserted without data mode");
    a_rx_mark_clamp: assert property (line_signal_detect_n_o |-> serial_rx_data_o)
        else $error("serial receive output not at mark");
    a_we_one_cycle: assert property (ram_we_o |=> !ram_we_o)
        else $error("ram write strobe longer than one cycle");
    a_oe_after_read: assert property ($rose(host_data_oe_o) |-> !$past(host_rd_n_i, 2) && !$past(host_cs_n_i, 2))
        else $error("data bus driven without a read strobe");
    a_oe_released: assert property (s_rd_idle |-> !host_data_oe_o)
        else $error("data bus still driven after read ended");
    a_reset_quiet: assert property ($fell(sys_rst_i) |-> host_irq_n_o && !host_data_oe_o)
        else $error("interrupt or bus drive active after reset");
    a_tx_hold: assert property (tx_byte_valid_o && !tx_byte_ready_i |=> tx_byte_valid_o && $stable(tx_byte_o))
        else $error("transmit byte changed while stalled");
    a_standby_drops: assert property ($rose(standby_i) |-> ##[1:3] line_signal_detect_n_o)
        else $error("carrier detect kept through standby");
endmodule : mhri_asserts
`default_nettype wire

// *** verif/mhri_host_model.sv ***
// host microprocessor model on the parallel register bus
`timescale 1ns/10ps
`default_nettype none
module mhri_host_model (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output logic [2:0] sel_o,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [7:0] wdata_o
);
    // ************
    // bus cycles
    // ************
    initial begin
        sel_o = 3'h0;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        wdata_o = 8'h00;
    end
    // strobe held 6 clocks and high 4 clocks, past the synchroniser lag
    task automatic access(input logic [2:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(negedge clock_i);
        sel_o = a;
        cs_n_o = 1'b0;
        wdata_o = d;
        if (w) wr_n_o = 1'b0;
        else rd_n_o = 1'b0;
        repeat (6) @(negedge clock_i);
        q = rdata_i;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        // released bus shows the inverse, not a stale value
        wdata_o = ~d;
        repeat (4) @(negedge clock_i);
    endtask : access
endmodule : mhri_host_model
`default_nettype wire

// *** verif/mhri_top_test.sv ***
// self-checking bench of the host register port
`timescale 1ns/10ps
`default_nettype none
`include "mhri_defines.svh"
bind mhri_top mhri_asserts u_chk (.clock_i, .sys_rst_i, .host_cs_n_i, .host_rd_n_i, .host_data_oe_o,
    .host_irq_n_o, .request_to_send_n_i, .transmit_mode_o, .line_signal_detect_n_o, .serial_rx_data_o,
    .standby_i, .data_mode_ready_i, .ram_we_o, .tx_byte_valid_o, .tx_byte_ready_i, .tx_byte_o);
module mhri_top_test;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, cs_n, rd_n, wr_n, oe, irq_n, txm, pm, lsd_n, srx_o, we, txv;
    logic rts_n = 1'b1, srx = 1'b0, stby = 1'b0, dmr = 1'b0, qam = 1'b0, rtr = 1'b0, dial = 1'b0;
    logic rxv = 1'b0, txr = 1'b0, fgood = 1'b0, fabort = 1'b0, tclose = 1'b0, tflag = 1'b0;
    logic rta = 1'b0, drn = 1'b1, fcrc = 1'b0, ffirst = 1'b0;
    logic [2:0] sel;
    logic [7:0] hdi, hdo, txb, rxb = 8'h00;
    logic [8:0] raddr, we_addr;
    logic [15:0] wdata, we_data, rdata = 16'h0000;
    int n_fail = 0, comparisons = 0, we_cnt = 0;
    always #25 clock_i = ~clock_i;
    mhri_host_model u_host (.clock_i(clock_i), .rdata_i(hdo), .sel_o(sel), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .wdata_o(hdi));
    mhri_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .register_select_i(sel), .host_cs_n_i(cs_n),
        .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_data_i(hdi), .host_data_o(hdo), .host_data_oe_o(oe),
        .host_irq_n_o(irq_n), .request_to_send_n_i(rts_n), .transmit_mode_o(txm), .parallel_mode_o(pm),
        .line_signal_detect_n_o(lsd_n), .serial_rx_data_i(srx), .serial_rx_data_o(srx_o), .standby_i(stby),
        .data_mode_ready_i(dmr), .qam2400_mode_i(qam), .retrain_seen_i(rtr), .retrain_active_i(rta),
        .dialing_i(dial), .tx_drained_i(drn), .ram_addr_o(raddr), .ram_we_o(we), .ram_wdata_o(wdata),
        .ram_rdata_i(rdata), .rx_byte_valid_i(rxv), .rx_byte_i(rxb), .tx_byte_valid_o(txv),
        .tx_byte_ready_i(txr), .tx_byte_o(txb), .rx_frame_good_i(fgood), .rx_frame_crc_err_i(fcrc),
        .rx_frame_abort_i(fabort), .rx_frame_first_i(ffirst), .tx_frame_close_i(tclose),
        .tx_closing_flag_i(tflag));
    always @(posedge clock_i) begin
        if (we === 1'b1) begin
            we_cnt <= we_cnt + 1;
            we_data <= wdata;
            we_addr <= raddr;
        end
    end
    // ****************
    // checks and bus
    // ****************
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: register read %h, wanted %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: port value %h, wanted %h", $time, got, exp);
        end
    endtask : chk_pin
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.access(a, 1'b1, d, q);
    endtask : wr
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.access(a, 1'b0, 8'h00, q);
        chk_reg(q, e);
    endtask : rd_chk
    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask : idle
    task final_report;
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // ***********
    // scenarios
    // ***********
    task automatic t_reset;
        rd_chk(3'h4, 8'h00);
        rd_chk(3'h5, 8'h40);
        rd_chk(3'h7, 8'h00);
        wr(3'h6, 8'hFF);
        rd_chk(3'h6, 8'h00);
        chk_pin(16'(irq_n), 16'h0001);
    endtask : t_reset
    task automatic t_ram;
        rdata = 16'hBEEF;
        wr(3'h2, 8'h34);
        wr(3'h4, 8'h03);
        rd_chk(3'h4, 8'h01);
        chk_pin(16'(raddr), 16'h0134);
        chk_pin(16'(we_cnt), 16'h0000);
        rd_chk(3'h0, 8'hEF);
        rd_chk(3'h1, 8'hBE);
        rd_chk(3'h5, 8'h60);
        rd_chk(3'h5, 8'h40);
        wr(3'h0, 8'h5A);
        wr(3'h1, 8'hC3);
        wr(3'h2, 8'hFF);
        wr(3'h4, 8'h27);
        rd_chk(3'h4, 8'h25);
        chk_pin(16'(we_cnt), 16'h0001);
        chk_pin(we_data, 16'hC35A);
        chk_pin(16'(we_addr), 16'h01FF);
        chk_pin(16'(irq_n), 16'h0000);
        rd_chk(3'h5, 8'h60);
        chk_pin(16'(irq_n), 16'h0001);
    endtask : t_ram
    task automatic t_parallel;
        wr(3'h4, 8'h50);
        chk_pin(16'(pm), 16'h0001);
        chk_pin(16'(irq_n), 16'h0000);
        rd_chk(3'h3, `MHRI_FW_VERSION);
        rd_chk(3'h5, 8'h00);
        chk_pin(16'(irq_n), 16'h0001);
        @(negedge clock_i);
        rxb = 8'hA5;
        rxv = 1'b1;
        @(negedge clock_i);
        rxv = 1'b0;
        rd_chk(3'h5, 8'h40);
        rd_chk(3'h3, 8'hA5);
        rd_chk(3'h5, 8'h00);
    endtask : t_parallel
    task automatic t_fifo;
        int n;
        wr(3'h4, 8'h90);
        // ninth byte meets a full buffer and is dropped
        for (int i = 0; i < 9; i++) wr(3'h3, 8'hB0 + 8'(i));
        n = 0;
        txr = 1'b1;
        // look before each edge: with ready high the first byte leaves at the next edge
        repeat (20) begin
            if (txv === 1'b1) begin
                chk_pin(16'(txb), 16'(8'hB0 + 8'(n)));
                n++;
            end
            @(negedge clock_i);
        end
        chk_pin(16'(n), 16'h0008);
        rd_chk(3'h5, 8'h80);
        chk_pin(16'(irq_n), 16'h0000);
    endtask : t_fifo
    task automatic t_modes;
        wr(3'h4, 8'h00);
        rts_n = 1'b0;
        idle(6);
        chk_pin(16'(txm), 16'h0001);
        rts_n = 1'b1;
        idle(6);
        chk_pin(16'(txm), 16'h0000);
        wr(3'h4, 8'h08);
        chk_pin(16'(txm), 16'h0001);
        drn = 1'b0;
        wr(3'h4, 8'h00);
        rd_chk(3'h5, 8'h90);
        drn = 1'b1;
        dmr = 1'b1;
        idle(6);
        chk_pin(16'({lsd_n, srx_o}), 16'h0000);
        qam = 1'b1;
        rtr = 1'b1;
        @(negedge clock_i);
        rtr = 1'b0;
        rd_chk(3'h5, 8'h86);
        rta = 1'b1;
        idle(2);
        chk_pin(16'(lsd_n), 16'h0001);
        rta = 1'b0;
        qam = 1'b0;
        dmr = 1'b0;
        idle(6);
        chk_pin(16'({lsd_n, srx_o}), 16'h0003);
        dial = 1'b1;
        dmr = 1'b1;
        rd_chk(3'h5, 8'h92);
        dial = 1'b0;
        stby = 1'b1;
        rd_chk(3'h5, 8'h80);
        chk_pin(16'(lsd_n), 16'h0001);
        rd_chk(3'h3, `MHRI_FW_VERSION);
        stby = 1'b0;
        dmr = 1'b0;
    endtask : t_modes
    task automatic t_hdlc;
        wr(3'h4, 8'h10);
        @(negedge clock_i);
        fabort = 1'b1;
        @(negedge clock_i);
        fabort = 1'b0;
        rd_chk(3'h7, 8'h03);
        rd_chk(3'h3, 8'hFF);
        fcrc = 1'b1;
        @(negedge clock_i);
        fcrc = 1'b0;
        rd_chk(3'h7, 8'h03);
        rd_chk(3'h3, `MHRI_FLAG_BYTE);
        @(negedge clock_i);
        tclose = 1'b1;
        @(negedge clock_i);
        tclose = 1'b0;
        rd_chk(3'h7, 8'h07);
        tflag = 1'b1;
        @(negedge clock_i);
        tflag = 1'b0;
        rd_chk(3'h7, 8'h03);
        fgood = 1'b1;
        @(negedge clock_i);
        fgood = 1'b0;
        rd_chk(3'h7, 8'h01);
        rd_chk(3'h5, 8'hC0);
        rd_chk(3'h3, `MHRI_FLAG_BYTE);
        ffirst = 1'b1;
        @(negedge clock_i);
        ffirst = 1'b0;
        rd_chk(3'h7, 8'h01);
        stby = 1'b1;
        idle(3);
        rd_chk(3'h7, 8'h00);
        rd_chk(3'h3, `MHRI_FW_VERSION);
    endtask : t_hdlc
    initial begin
        idle(10);
        sys_rst_i = 1'b0;
        idle(2);
        t_reset();
        t_ram();
        t_parallel();
        t_fifo();
        t_modes();
        t_hdlc();
        final_report();
    end
    initial begin
        #(20000 * 50);
        n_fail++;
        final_report();
    end
endmodule : mhri_top_test
`default_nettype wire
